// ===== rtl/hbra_cfg.svh
`ifndef HBRA_CFG_SVH
`define HBRA_CFG_SVH

// Register counts and pointer widths
`define HBRA_SER_REGS 16
`define HBRA_DMA_REGS 32
`define HBRA_SER_PTR_W 4
`define HBRA_DMA_PTR_W 5

// Serial command register fields
`define HBRA_CMD_PTR_MSB 2
`define HBRA_CMD_CODE_MSB 5
`define HBRA_CMD_CODE_LSB 3
`define HBRA_CMD_POINT_HIGH 3'h1
`define HBRA_SHIFT_LEFT_CODE 2'h2

// Bus configuration fields and reset value
`define HBRA_BCR_LEFT_BIT 0
`define HBRA_BCR_MUX_BIT 1
`define HBRA_BCR_RST 8'h00

// Host command port offsets
`define HBRA_H_TARGET 3'h0
`define HBRA_H_DATA 3'h1
`define HBRA_H_CTRL 3'h2
`define HBRA_H_STATUS 3'h3
`define HBRA_H_CFG 3'h4
`define HBRA_H_RDBACK 3'h5

// Host register fields
`define HBRA_T_CHAN_BIT 5
`define HBRA_T_SECT_BIT 6
`define HBRA_C_READ_BIT 0
`define HBRA_C_RAW_BIT 1
`define HBRA_G_MUX_BIT 0
`define HBRA_G_SLEFT_BIT 1
`define HBRA_G_DLEFT_BIT 2

`endif

// ===== rtl/hbra_pkg.sv
package hbra_pkg;
   typedef enum logic [2:0] {
      HST_IDLE,
      HST_PTR,
      HST_ADDR,
      HST_ACC,
      HST_CAP
   } hbra_hstate_t;
endpackage : hbra_pkg

// ===== rtl/hbra_if.sv
`timescale 1ns/100ps
interface hbra_if;
   logic ce_n;
   logic as;
   logic wr;
   logic rd;
   logic [15:0] ad_h_o;
   logic ad_h_oe;
   logic [15:0] ad_d_o;
   logic ad_d_oe;
   logic sect_h_o;
   logic sect_h_oe;
   logic sect_d_o;
   logic sect_d_oe;
   logic chan_h_o;
   logic chan_h_oe;
   logic chan_d_o;
   logic chan_d_oe;
   // Wire levels resolved from the enables; an undriven bus reads low
   logic [15:0] ad;
   logic sect;
   logic chan;
   assign ad = ad_d_oe ? ad_d_o : (ad_h_oe ? ad_h_o : 16'h0000);
   assign sect = sect_d_oe ? sect_d_o : (sect_h_oe ? sect_h_o : 1'b0);
   assign chan = chan_d_oe ? chan_d_o : (chan_h_oe ? chan_h_o : 1'b0);

   modport device (
      input ce_n, as, wr, rd, ad, sect, chan,
      output ad_d_o, ad_d_oe, sect_d_o, sect_d_oe, chan_d_o, chan_d_oe
   );
   modport host (
      input ad,
      output ce_n, as, wr, rd, ad_h_o, ad_h_oe, sect_h_o, sect_h_oe, chan_h_o, chan_h_oe
   );
endinterface : hbra_if

// ===== rtl/hbra_ptr.sv
`timescale 1ns/100ps
// Self-clearing register pointer: a load arms it, the next access clears it
module hbra_ptr #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic access,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic [W-1:0] ptr,
   output logic armed
);
   logic [W-1:0] ptr_reg;
   logic [W-1:0] ptr_next;
   logic armed_reg;
   logic armed_next;

   // Clearing wins so a stale target never survives the second access
   always_comb begin
      ptr_next = ptr_reg;
      armed_next = armed_reg;
      if (access && armed_reg) begin
         ptr_next = '0;
         armed_next = 1'b0;
      end else if (load) begin
         ptr_next = load_val;
         armed_next = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_reg <= '0;
         armed_reg <= 1'b0;
      end else begin
         ptr_reg <= ptr_next;
         armed_reg <= armed_next;
      end
   end

   assign ptr = ptr_reg;
   assign armed = armed_reg;
endmodule : hbra_ptr

// ===== rtl/hbra_dev.sv
// How it works
// - Bus mode comes from first write after reset
// - Multiplexed mode addresses every register directly
// - Non-multiplexed mode uses pointer loaded by write
// - Accesses count only while chip enable asserted
// - Section select low routes to DMA section
// - Section high: channel A if select high
// - Section/channel pins driven only as DMA master
// - Serial write: command pointer, then target write
// - Serial read: command pointer, then target read
// - Serial pointer clears after second access
// - Non-multiplexed data registers reached only via pointer
// - DMA and serial pointers fully independent
// - DMA pointer is low five command bits
// - DMA pointer clears after second access
// - Mux address from AD5-1 or AD4-0
// - Shift mode: command bits 1:0, config bit 0
// - Eight-bit slave: low lane in, replicated out
`timescale 1ns/100ps
`include "hbra_cfg.svh"
module hbra_dev #(
   parameter int SER_REGS = `HBRA_SER_REGS,
   parameter int DMA_REGS = `HBRA_DMA_REGS
) (
   input wire logic MCLK,
   input wire logic SYS_RST,
   hbra_if.device BUS,
   input wire logic DMA_OWN,
   input wire logic DMA_SECT,
   input wire logic DMA_CHAN,
   output logic CFG_DONE,
   output logic MUX_MODE,
   output logic SER_LEFT,
   output logic DMA_LEFT,
   output logic [`HBRA_SER_PTR_W-1:0] SER_PTR,
   output logic [`HBRA_DMA_PTR_W-1:0] DMA_PTR
);
   localparam int SW = `HBRA_SER_PTR_W;
   localparam int DW = `HBRA_DMA_PTR_W;

   // Register storage and bus state
   logic [7:0] ser_mem_reg [2][SER_REGS];
   logic [7:0] ser_mem_next [2][SER_REGS];
   logic [7:0] dma_mem_reg [DMA_REGS];
   logic [7:0] dma_mem_next [DMA_REGS];
   logic cfg_done_reg;
   logic cfg_done_next;
   logic [7:0] bcr_reg;
   logic [7:0] bcr_next;
   logic [1:0] ser_shift_reg;
   logic [1:0] ser_shift_next;
   logic [5:0] lat_reg;
   logic [5:0] lat_next;
   logic [15:0] rd_data_reg;
   logic [15:0] rd_data_next;
   logic rd_oe_reg;
   logic rd_oe_next;
   logic own_reg;
   logic sect_out_reg;
   logic chan_out_reg;

   // Decode signals
   logic mux;
   logic acc;
   logic is_dma;
   logic ch;
   logic ser_left;
   logic dma_left;
   logic [4:0] ser_addr;
   logic [4:0] dma_addr;
   logic [SW-1:0] ser_idx;
   logic [DW-1:0] dma_idx;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic ser_acc;
   logic dma_acc;
   logic ser_load;
   logic dma_load;
   logic [SW-1:0] ser_load_val;
   logic [SW-1:0] ser_ptr;
   logic ser_armed;
   logic [DW-1:0] dma_ptr;
   logic dma_armed;

   assign mux = bcr_reg[`HBRA_BCR_MUX_BIT];
   assign ser_left = (ser_shift_reg == `HBRA_SHIFT_LEFT_CODE);
   assign dma_left = bcr_reg[`HBRA_BCR_LEFT_BIT];
   assign wbyte = BUS.ad[7:0];
   // Accepted strobe; ignored entirely without chip enable
   assign acc = !BUS.ce_n && (BUS.wr || BUS.rd) && cfg_done_reg;
   assign is_dma = !BUS.sect;
   assign ch = !BUS.chan;

   // Latched multiplexed address decoded per section shift mode
   assign ser_addr = ser_left ? lat_reg[5:1] : lat_reg[4:0];
   assign dma_addr = dma_left ? lat_reg[5:1] : lat_reg[4:0];

   // Target register: direct in mux mode, pointer otherwise
   always_comb begin
      if (mux) begin
         ser_idx = ser_addr[SW-1:0];
         dma_idx = dma_addr[DW-1:0];
      end else begin
         ser_idx = ser_armed ? ser_ptr : '0;
         dma_idx = dma_armed ? dma_ptr : '0;
      end
   end

   // Pointer strobes stay within their own section
   assign ser_acc = acc && !mux && !is_dma;
   assign dma_acc = acc && !mux && is_dma;
   assign ser_load = ser_acc && BUS.wr && !ser_armed;
   assign dma_load = dma_acc && BUS.wr && !dma_armed;
   assign ser_load_val = {wbyte[`HBRA_CMD_CODE_MSB:`HBRA_CMD_CODE_LSB] == `HBRA_CMD_POINT_HIGH,
                          wbyte[`HBRA_CMD_PTR_MSB:0]};

   // Serial pointer, cleared after the second access
   hbra_ptr #(.W(SW)) u_ser_ptr (
      .clk(MCLK),
      .rst(SYS_RST),
      .access(ser_acc),
      .load(ser_load),
      .load_val(ser_load_val),
      .ptr(ser_ptr),
      .armed(ser_armed)
   );

   // DMA pointer, independent of the serial one
   hbra_ptr #(.W(DW)) u_dma_ptr (
      .clk(MCLK),
      .rst(SYS_RST),
      .access(dma_acc),
      .load(dma_load),
      .load_val(wbyte[DW-1:0]),
      .ptr(dma_ptr),
      .armed(dma_armed)
   );

   // Read byte; register 0 of each section reads back live pointer state
   always_comb begin
      if (is_dma) begin
         rbyte = (dma_idx == '0) ? {3'h0, dma_ptr} : dma_mem_reg[dma_idx];
      end else if (ser_idx == '0) begin
         rbyte = {cfg_done_reg, mux, ser_armed, 1'b0, ser_ptr};
      end else begin
         rbyte = ser_mem_reg[ch][ser_idx];
      end
   end

   // Next state of configuration, storage and read path
   always_comb begin
      ser_mem_next = ser_mem_reg;
      dma_mem_next = dma_mem_reg;
      cfg_done_next = cfg_done_reg;
      bcr_next = bcr_reg;
      ser_shift_next = ser_shift_reg;
      lat_next = lat_reg;
      rd_data_next = rd_data_reg;
      rd_oe_next = 1'b0;
      // First write after reset programs the bus configuration
      if (!cfg_done_reg && !BUS.ce_n && BUS.wr) begin
         bcr_next = wbyte;
         cfg_done_next = 1'b1;
      end
      // Address phase of a multiplexed cycle
      if (!BUS.ce_n && BUS.as && mux) begin
         lat_next = BUS.ad[5:0];
      end
      if (acc && BUS.wr) begin
         if (is_dma) begin
            dma_mem_next[dma_idx] = wbyte;
         end else begin
            ser_mem_next[ch][ser_idx] = wbyte;
            if (mux && ser_idx == '0) begin
               ser_shift_next = wbyte[1:0];
            end
         end
      end
      if (acc && BUS.rd) begin
         rd_data_next = {rbyte, rbyte};
         rd_oe_next = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < SER_REGS; i++) begin
               ser_mem_reg[c][i] <= 8'h00;
            end
         end
         for (int i = 0; i < DMA_REGS; i++) begin
            dma_mem_reg[i] <= 8'h00;
         end
         cfg_done_reg <= 1'b0;
         bcr_reg <= `HBRA_BCR_RST;
         ser_shift_reg <= 2'h0;
         lat_reg <= 6'h00;
         rd_data_reg <= 16'h0000;
         rd_oe_reg <= 1'b0;
      end else begin
         ser_mem_reg <= ser_mem_next;
         dma_mem_reg <= dma_mem_next;
         cfg_done_reg <= cfg_done_next;
         bcr_reg <= bcr_next;
         ser_shift_reg <= ser_shift_next;
         lat_reg <= lat_next;
         rd_data_reg <= rd_data_next;
         rd_oe_reg <= rd_oe_next;
      end
   end

   // Select pins become outputs only while this end owns the bus for DMA
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         own_reg <= 1'b0;
         sect_out_reg <= 1'b0;
         chan_out_reg <= 1'b0;
      end else begin
         own_reg <= DMA_OWN;
         sect_out_reg <= DMA_SECT;
         chan_out_reg <= DMA_CHAN;
      end
   end

   // Pin and user-side outputs
   assign BUS.ad_d_o = rd_data_reg;
   assign BUS.ad_d_oe = rd_oe_reg;
   assign BUS.sect_d_o = sect_out_reg;
   assign BUS.sect_d_oe = own_reg;
   assign BUS.chan_d_o = chan_out_reg;
   assign BUS.chan_d_oe = own_reg;
   assign CFG_DONE = cfg_done_reg;
   assign MUX_MODE = mux;
   assign SER_LEFT = ser_left;
   assign DMA_LEFT = dma_left;
   assign SER_PTR = ser_ptr;
   assign DMA_PTR = dma_ptr;
endmodule : hbra_dev

// ===== rtl/hbra_host.sv
`timescale 1ns/100ps
`include "hbra_cfg.svh"
module hbra_host (
   input wire logic MCLK,
   input wire logic SYS_RST,
   hbra_if.host BUS,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA
);
   hbra_pkg::hbra_hstate_t state_reg;
   hbra_pkg::hbra_hstate_t state_next;
   logic [6:0] target_reg;
   logic [6:0] target_next;
   logic [7:0] data_reg;
   logic [7:0] data_next;
   logic [2:0] cfg_reg;
   logic [2:0] cfg_next;
   logic [1:0] ctl_reg;
   logic [1:0] ctl_next;
   logic [7:0] rdback_reg;
   logic [7:0] rdback_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   logic busy;
   logic sect;
   logic [4:0] raddr;
   logic left;
   logic [7:0] ptr_byte;
   logic [5:0] mux_addr;

   assign busy = (state_reg != hbra_pkg::HST_IDLE);
   assign sect = target_reg[`HBRA_T_SECT_BIT];
   assign raddr = target_reg[4:0];
   assign left = sect ? cfg_reg[`HBRA_G_SLEFT_BIT] : cfg_reg[`HBRA_G_DLEFT_BIT];
   // Pointer byte: serial uses three bits plus point-high, DMA five bits
   assign ptr_byte = sect ? {2'h0, raddr[3] ? `HBRA_CMD_POINT_HIGH : 3'h0, raddr[2:0]}
                          : {3'h0, raddr};
   assign mux_addr = left ? {raddr, 1'b0} : {1'b0, raddr};

   // Command port and transfer sequencer
   always_comb begin
      state_next = state_reg;
      target_next = target_reg;
      data_next = data_reg;
      cfg_next = cfg_reg;
      ctl_next = ctl_reg;
      rdback_next = rdback_reg;
      rdata_next = 8'h00;
      if (WR && !busy) begin
         unique case (ADDR)
            `HBRA_H_TARGET: target_next = WDATA[6:0];
            `HBRA_H_DATA: data_next = WDATA;
            `HBRA_H_CFG: cfg_next = WDATA[2:0];
            `HBRA_H_CTRL: begin
               ctl_next = WDATA[1:0];
               if (WDATA[`HBRA_C_RAW_BIT]) begin
                  state_next = hbra_pkg::HST_ACC;
               end else if (cfg_reg[`HBRA_G_MUX_BIT]) begin
                  state_next = hbra_pkg::HST_ADDR;
               end else if (raddr == 5'h00) begin
                  state_next = hbra_pkg::HST_ACC;
               end else begin
                  state_next = hbra_pkg::HST_PTR;
               end
            end
            default: ;
         endcase
      end
      if (RD) begin
         unique case (ADDR)
            `HBRA_H_TARGET: rdata_next = {1'b0, target_reg};
            `HBRA_H_DATA: rdata_next = data_reg;
            `HBRA_H_CFG: rdata_next = {5'h00, cfg_reg};
            `HBRA_H_CTRL: rdata_next = {6'h00, ctl_reg};
            `HBRA_H_STATUS: rdata_next = {7'h00, busy};
            `HBRA_H_RDBACK: rdata_next = rdback_reg;
            default: rdata_next = 8'h00;
         endcase
      end
      unique case (state_reg)
         hbra_pkg::HST_IDLE: ;
         hbra_pkg::HST_PTR: state_next = hbra_pkg::HST_ACC;
         hbra_pkg::HST_ADDR: state_next = hbra_pkg::HST_ACC;
         hbra_pkg::HST_ACC: begin
            state_next = ctl_reg[`HBRA_C_READ_BIT] ? hbra_pkg::HST_CAP : hbra_pkg::HST_IDLE;
         end
         hbra_pkg::HST_CAP: begin
            rdback_next = BUS.ad[7:0];
            state_next = hbra_pkg::HST_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg <= hbra_pkg::HST_IDLE;
         target_reg <= 7'h00;
         data_reg <= 8'h00;
         cfg_reg <= 3'h0;
         ctl_reg <= 2'h0;
         rdback_reg <= 8'h00;
         rdata_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         target_reg <= target_next;
         data_reg <= data_next;
         cfg_reg <= cfg_next;
         ctl_reg <= ctl_next;
         rdback_reg <= rdback_next;
         rdata_reg <= rdata_next;
      end
   end

   // Bus pins; a pointer write precedes the access except in raw, multiplexed or register 0 transfers
   assign BUS.ce_n = !busy;
   assign BUS.as = (state_reg == hbra_pkg::HST_ADDR);
   assign BUS.wr = (state_reg == hbra_pkg::HST_PTR) ||
                   (state_reg == hbra_pkg::HST_ACC && !ctl_reg[`HBRA_C_READ_BIT]);
   assign BUS.rd = (state_reg == hbra_pkg::HST_ACC) && ctl_reg[`HBRA_C_READ_BIT];
   assign BUS.ad_h_oe = (state_reg == hbra_pkg::HST_PTR) || (state_reg == hbra_pkg::HST_ADDR) ||
                        (state_reg == hbra_pkg::HST_ACC && !ctl_reg[`HBRA_C_READ_BIT]);
   always_comb begin
      unique case (state_reg)
         hbra_pkg::HST_PTR: BUS.ad_h_o = {8'h00, ptr_byte};
         hbra_pkg::HST_ADDR: BUS.ad_h_o = {10'h000, mux_addr};
         default: BUS.ad_h_o = {8'h00, data_reg};
      endcase
   end
   assign BUS.sect_h_o = sect;
   assign BUS.sect_h_oe = busy;
   assign BUS.chan_h_o = target_reg[`HBRA_T_CHAN_BIT];
   assign BUS.chan_h_oe = busy;
   assign RDATA = rdata_reg;
endmodule : hbra_host

// ===== bench/hbra_properties.sv
`timescale 1ns/100ps
module hbra_properties (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic ce_n,
   input wire logic as,
   input wire logic wr,
   input wire logic rd,
   input wire logic ad_h_oe,
   input wire logic [15:0] ad_d_o,
   input wire logic ad_d_oe,
   input wire logic sect_d_oe,
   input wire logic chan_d_oe
);
   // One clock domain; reset voids every check
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);

   // Device side of the link
   answer_cause_a: assert property (
      ad_d_oe |-> $past(rd) && !$past(ce_n)) else $error("Answer without selected read");
   answer_pulse_a: assert property (
      rd && !ce_n |=> ad_d_oe ##1 !ad_d_oe) else $error("Read answer not one cycle");
   lane_copy_a: assert property (
      ad_d_oe |-> ad_d_o[15:8] == ad_d_o[7:0]) else $error("Upper lane not a copy");
   no_fight_a: assert property (
      ad_d_oe |-> !ad_h_oe) else $error("Both ends drive the bus");
   pin_pair_a: assert property (
      sect_d_oe == chan_d_oe) else $error("Select pins not driven together");

   // Host side of the link
   strobe_select_a: assert property (
      wr || rd |-> !ce_n) else $error("Strobe without chip enable");
   addr_phase_a: assert property (
      as |-> (!ce_n && ad_h_oe) ##1 (wr || rd)) else $error("Address phase malformed");
   write_drive_a: assert property (
      wr |-> ad_h_oe) else $error("Write without data on bus");
   // A direct read of register 0 may open a frame with the read strobe itself
   frame_start_a: assert property (
      $fell(ce_n) |-> (wr || as || rd)) else $error("Frame opens without any strobe");
endmodule : hbra_properties

// ===== bench/hbra_bench.sv
`timescale 1ns/100ps
`include "hbra_cfg.svh"
module hbra_bench;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] haddr = 3'h0;
   logic [7:0] hwdata = 8'h00;
   logic host_wr = 1'b0;
   logic host_rd = 1'b0;
   logic dma_own = 1'b0;
   logic dma_sect = 1'b0;
   logic dma_chan = 1'b0;
   logic [7:0] rdata;
   logic cfg_done, mux_mode, ser_left, dma_left;
   logic [3:0] ser_ptr;
   logic [4:0] dma_ptr;
   logic [15:0] st;
   logic rd_d = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] va, vb, vc;
   logic [7:0] sreg[3] = '{8'h03, 8'h08, 8'h0f};
   logic [7:0] dreg[3] = '{8'h01, 8'h14, 8'h1f};
   int n_mismatch = 0;
   int tests_run = 0;
   int seed = 32'h0000_c2c5;
   int i;

   // Clock and the two ends joined by the carrier
   always #2.5 mclk = ~mclk;
   hbra_if bus ();
   hbra_dev i_hbra_dev (.MCLK(mclk), .SYS_RST(sys_rst), .BUS(bus), .DMA_OWN(dma_own),
      .DMA_SECT(dma_sect), .DMA_CHAN(dma_chan), .CFG_DONE(cfg_done), .MUX_MODE(mux_mode),
      .SER_LEFT(ser_left), .DMA_LEFT(dma_left), .SER_PTR(ser_ptr), .DMA_PTR(dma_ptr));
   hbra_host i_hbra_host (.MCLK(mclk), .SYS_RST(sys_rst), .BUS(bus), .ADDR(haddr),
      .WDATA(hwdata), .WR(host_wr), .RD(host_rd), .RDATA(rdata));
   hbra_properties i_hbra_properties (.MCLK(mclk), .SYS_RST(sys_rst), .ce_n(bus.ce_n),
      .as(bus.as), .wr(bus.wr), .rd(bus.rd), .ad_h_oe(bus.ad_h_oe), .ad_d_o(bus.ad_d_o),
      .ad_d_oe(bus.ad_d_oe), .sect_d_oe(bus.sect_d_oe), .chan_d_oe(bus.chan_d_oe));
   // Flags and both pointers packed for one comparison
   assign st = {cfg_done, mux_mode, ser_left, dma_left, ser_ptr, 3'h0, dma_ptr};

   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t state %h want %h", $time, got, exp);
      end
   endtask : cmp_val

   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t read %h want %h", $time, got, exp);
      end
   endtask : cmp_rd

   // A gap edge first, so a strobe is never set and cleared in one step
   task automatic hwr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      haddr <= a;
      hwdata <= d;
      host_wr <= 1'b1;
      @(posedge mclk);
      host_wr <= 1'b0;
   endtask : hwr

   // Note the expected byte, then read one command port register
   task automatic rdp(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge mclk);
      haddr <= a;
      host_rd <= 1'b1;
      @(posedge mclk);
      host_rd <= 1'b0;
   endtask : rdp

   // Read back the byte that the last link read captured
   task automatic rdb(input logic [7:0] e);
      rdp(`HBRA_H_RDBACK, e);
   endtask : rdb

   // One link transfer; ends once chip enable has gone back high
   task automatic xfer(input logic [7:0] tgt, input logic [7:0] d, input logic [7:0] ctl);
      int n;
      hwr(`HBRA_H_TARGET, tgt);
      hwr(`HBRA_H_DATA, d);
      hwr(`HBRA_H_CTRL, ctl);
      repeat (2) @(posedge mclk);
      for (n = 0; n < 40 && bus.ce_n !== 1'b1; n++) @(posedge mclk);
      // A frame that never closes counts against the run
      if (bus.ce_n !== 1'b1) begin
         n_mismatch++;
         $display("BAD %0t link transfer never ended", $time);
      end
      @(posedge mclk);
   endtask : xfer

   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
   endtask : do_reset

   task automatic stop_test();
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   // Read results land the cycle after the strobe; check the oldest note
   always @(posedge mclk) begin
      rd_d <= host_rd;
      if (rd_d)
         cmp_rd(rdata, exp_q.pop_front());
   end

   // Cut a hang short well beyond the expected run length
   initial begin
      repeat (8000) @(posedge mclk);
      n_mismatch++;
      stop_test();
   end

   // Main sequence: non-multiplexed run, then a fresh reset into multiplexed mode
   initial begin
      do_reset();
      cmp_val(st, 16'h0000);
      hwr(`HBRA_H_CFG, 8'h00);
      xfer(8'h60, 8'h00, 8'h02);
      cmp_val(st, 16'h8000);
      // Both channels and the DMA section interleaved, DMA read with the other channel
      for (i = 0; i < 3; i++) begin
         va = 8'($random(seed));
         vb = 8'($random(seed));
         vc = 8'($random(seed));
         xfer(8'h60 | sreg[i], va, 8'h00);
         xfer(8'h40 | sreg[i], vb, 8'h00);
         xfer(8'h20 | dreg[i], vc, 8'h00);
         xfer(8'h60 | sreg[i], 8'h00, 8'h01);
         rdb(va);
         xfer(8'h40 | sreg[i], 8'h00, 8'h01);
         rdb(vb);
         xfer(dreg[i], 8'h00, 8'h01);
         rdb(vc);
         cmp_val(st, 16'h8000);
      end
      // Unarmed pointers: register 0 of each section reads pointer state
      xfer(8'h60, 8'h00, 8'h01);
      rdb(8'h80);
      xfer(8'h00, 8'h00, 8'h01);
      rdb(8'h00);
      // Raw accesses arm one pointer while the other is live
      xfer(8'h60, 8'h0b, 8'h02);
      cmp_val(st, 16'h8b00);
      xfer(8'h00, 8'h11, 8'h02);
      cmp_val(st, 16'h8b11);
      va = 8'($random(seed));
      xfer(8'h00, va, 8'h02);
      cmp_val(st, 16'h8b00);
      vb = 8'($random(seed));
      xfer(8'h60, vb, 8'h02);
      cmp_val(st, 16'h8000);
      xfer(8'h6b, 8'h00, 8'h01);
      rdb(vb);
      xfer(8'h11, 8'h00, 8'h01);
      rdb(va);
      // Select pins driven only while the device owns the bus
      dma_own <= 1'b1;
      dma_sect <= 1'b1;
      dma_chan <= 1'b0;
      repeat (2) @(posedge mclk);
      cmp_val({13'h0000, bus.sect_d_oe, bus.sect, bus.chan}, 16'h0006);
      dma_own <= 1'b0;
      repeat (2) @(posedge mclk);
      cmp_val({13'h0000, bus.sect_d_oe, bus.sect, bus.chan}, 16'h0000);
      // Second reset, then multiplexed mode with left shift in both sections
      do_reset();
      cmp_val(st, 16'h0000);
      hwr(`HBRA_H_CFG, 8'h05);
      rdp(`HBRA_H_CFG, 8'h05);
      xfer(8'h60, 8'h03, 8'h02);
      cmp_val(st, 16'hd000);
      xfer(8'h60, 8'h02, 8'h00);
      cmp_val(st, 16'hf000);
      hwr(`HBRA_H_CFG, 8'h07);
      va = 8'($random(seed));
      vb = 8'($random(seed));
      xfer(8'h4d, va, 8'h00);
      xfer(8'h39, vb, 8'h00);
      xfer(8'h4d, 8'h00, 8'h01);
      rdb(va);
      xfer(8'h19, 8'h00, 8'h01);
      rdb(vb);
      cmp_val(st, 16'hf000);
      repeat (4) @(posedge mclk);
      stop_test();
   end
endmodule : hbra_bench
